//--- inc/nv_access_pkg.sv
`default_nettype none
package nv_access_pkg;

  // ==========================================================
  // Register map (byte addresses, one aligned word each)
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h04;
  localparam logic [7:0] OFS_DATA      = 8'h08;
  localparam logic [7:0] OFS_CONTROL   = 8'h0c;
  localparam logic [7:0] OFS_UNLOCK    = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;

  // ==========================================================
  // Field positions
  localparam int CTL_RD     = 0;
  localparam int CTL_WR     = 1;
  localparam int CTL_WALLOW = 2;
  localparam int CTL_WERR   = 3;
  localparam int CTL_CFG    = 6;
  localparam int CTL_MSEL   = 7;
  localparam int IRQ_DONE   = 6;

  // ==========================================================
  // Values and sizes
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] KEY_FIRST   = 8'h5a;
  localparam logic [7:0] KEY_SECOND  = 8'ha5;
  localparam int         MEM_BYTES   = 1024;
  localparam int         MEM_AW      = 10;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WRITE_TIME_US = 4000;
  localparam int WRITE_CYCLES  = (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_ERASE = 2'b10,
    ST_PROG  = 2'b11
  } op_state_t;

  typedef enum logic [1:0] {
    UNLK_NONE  = 2'b00,
    UNLK_FIRST = 2'b01,
    UNLK_ARMED = 2'b10
  } unlock_t;

  typedef struct packed {
    logic              wr;
    logic              cfg;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        data;
  } ext_req_t;

endpackage : nv_access_pkg
`default_nettype wire

//--- logic/data_eeprom_access.sv
// Behaviour
// - One byte per access through data register
// - Write erases location, then programs byte
// - Internal timer sets write duration
// - High address keeps only two bits
// - Ten-bit address spans 1024 bytes
// - Memory select picks EEPROM or program
// - Config select targets configuration registers
// - Write needs write allow; clear at reset
// - Error flag on aborted or improper write
// - Write start set only; hardware clears
// - Done flag bit 6, software clears
// - Read and write starts self-clear
// - Read refused while program memory selected
// - Unlock register stores nothing, reads zero
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access
  import nv_access_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
)(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        ext_rdata,
  output ext_req_t               ext_req,
  output logic                   irq
);

  // ==========================================================
  // Elaboration checks
  localparam int TMR_W = $clog2(WRITE_CYCLES_P + 1);
  localparam logic [TMR_W-1:0] ERASE_LEN = TMR_W'(WRITE_CYCLES_P / 2);
  localparam logic [TMR_W-1:0] PROG_LEN  = TMR_W'(WRITE_CYCLES_P - WRITE_CYCLES_P / 2);

  if (WRITE_CYCLES_P < 2)
  begin : g_bad_cycles
    $error("WRITE_CYCLES_P must be at least 2");
  end

  // ==========================================================
  // State
  logic [ADDR_W-1:0] aw_addr_q;
  logic              aw_full_q;
  logic [7:0]        w_byte_q;
  logic              w_lane_q;
  logic              w_full_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [1:0]        addr_hi_q;
  logic [7:0]        addr_lo_q;
  logic [7:0]        data_q;
  logic              msel_q;
  logic              cfg_q;
  logic              wallow_q;
  logic              werr_q;
  unlock_t           unlock_q;
  op_state_t         st_q;
  logic [TMR_W-1:0]  timer_q;
  logic [MEM_AW-1:0] op_addr_q;
  logic [7:0]        op_data_q;
  logic              op_ext_q;
  logic              op_cfg_q;
  logic              stat_q;
  logic              mask_q;
  logic              irq_q;
  ext_req_t          ext_q;
  logic [7:0]        mem_q [MEM_BYTES];

  // ==========================================================
  // Write decode
  wire       wr_fire  = aw_full_q & w_full_q & ~bvalid_q;
  wire       wr_lane  = wr_fire & w_lane_q;
  wire [7:0] wbyte    = w_byte_q;
  wire       hit_hi   = wr_lane & (aw_addr_q == OFS_ADDR_HIGH);
  wire       hit_lo   = wr_lane & (aw_addr_q == OFS_ADDR_LOW);
  wire       hit_dat  = wr_lane & (aw_addr_q == OFS_DATA);
  wire       hit_ctl  = wr_lane & (aw_addr_q == OFS_CONTROL);
  wire       hit_unl  = wr_lane & (aw_addr_q == OFS_UNLOCK);
  wire       hit_stat = wr_lane & (aw_addr_q == OFS_IRQ_STAT);
  wire       hit_mask = wr_lane & (aw_addr_q == OFS_IRQ_MASK);
  wire       idle     = (st_q == ST_IDLE);
  wire       wr_busy  = (st_q == ST_ERASE) | (st_q == ST_PROG);

  // Address decode, shared by both channels
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFS_ADDR_HIGH) | (a == OFS_ADDR_LOW) | (a == OFS_DATA) |
             (a == OFS_CONTROL) | (a == OFS_UNLOCK) | (a == OFS_IRQ_STAT) |
             (a == OFS_IRQ_MASK);
  endfunction : mapped

  // Operation launch
  wire wr_req   = hit_ctl & wbyte[CTL_WR] & idle;
  wire wr_go    = wr_req & wallow_q & (unlock_q == UNLK_ARMED);
  wire wr_bad   = wr_req & ~wr_go;
  wire rd_go    = hit_ctl & wbyte[CTL_RD] & ~wbyte[CTL_MSEL] & ~wr_req & idle;
  wire tmr_end  = (timer_q == '0);
  wire erase_dn = (st_q == ST_ERASE) & tmr_end;
  wire prog_dn  = (st_q == ST_PROG) & tmr_end;
  wire [MEM_AW-1:0] cur_addr = {addr_hi_q, addr_lo_q};

  // Read mux
  wire [7:0] ctl_view = {msel_q, cfg_q, 2'b00, werr_q, wallow_q, wr_busy, st_q == ST_READ};
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = RESET_BYTE;
    case (s_axi_araddr)
      OFS_ADDR_HIGH: rd_byte = {6'h00, addr_hi_q};
      OFS_ADDR_LOW:  rd_byte = addr_lo_q;
      OFS_DATA:      rd_byte = data_q;
      OFS_CONTROL:   rd_byte = ctl_view;
      OFS_UNLOCK:    rd_byte = 8'h00;
      OFS_IRQ_STAT:  rd_byte = {1'b0, stat_q, 6'h00};
      OFS_IRQ_MASK:  rd_byte = {1'b0, mask_q, 6'h00};
      default:       rd_byte = RESET_BYTE;
    endcase
  end

  // ==========================================================
  // AXI4-Lite write channels
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_addr_q <= '0;
      w_byte_q  <= RESET_BYTE;
      w_lane_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && awready_q)
      begin
        aw_addr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channels
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && arready_q)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= {24'h000000, rd_byte};
        rresp_q   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_q && s_axi_rready)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Address and control registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_hi_q <= 2'b00;
      addr_lo_q <= RESET_BYTE;
      msel_q    <= 1'b0;
      cfg_q     <= 1'b0;
      wallow_q  <= 1'b0;
      // Cut write raises the flag; a raised flag survives reset
      if (wr_busy || werr_q)
        werr_q <= 1'b1;
      else
        werr_q <= 1'b0;
    end
    else if (ce)
    begin
      if (hit_hi)
        addr_hi_q <= wbyte[1:0];
      if (hit_lo)
        addr_lo_q <= wbyte;
      if (hit_ctl)
      begin
        msel_q   <= wbyte[CTL_MSEL];
        cfg_q    <= wbyte[CTL_CFG];
        wallow_q <= wbyte[CTL_WALLOW];
      end
      // Set beats a software clear
      if (wr_bad)
        werr_q <= 1'b1;
      else if (hit_ctl && !wbyte[CTL_WERR])
        werr_q <= 1'b0;
    end
  end

  // Unlock sequencer, no stored value
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      unlock_q <= UNLK_NONE;
    else if (ce && wr_fire)
    begin
      if (hit_unl && wbyte == KEY_FIRST)
        unlock_q <= UNLK_FIRST;
      else if (hit_unl && wbyte == KEY_SECOND && unlock_q == UNLK_FIRST)
        unlock_q <= UNLK_ARMED;
      else
        unlock_q <= UNLK_NONE;
    end
  end

  // ==========================================================
  // Operation sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q      <= ST_IDLE;
      timer_q   <= '0;
      op_addr_q <= '0;
      op_data_q <= RESET_BYTE;
      op_ext_q  <= 1'b0;
      op_cfg_q  <= 1'b0;
    end
    else if (ce)
    begin
      case (st_q)
        ST_IDLE:
          if (wr_go || rd_go)
          begin
            st_q      <= wr_go ? ST_ERASE : ST_READ;
            timer_q   <= ERASE_LEN - 1'b1;
            op_addr_q <= cur_addr;
            op_data_q <= data_q;
            op_ext_q  <= msel_q | cfg_q;
            op_cfg_q  <= cfg_q;
          end
        ST_READ:
          st_q <= ST_IDLE;
        ST_ERASE:
          if (tmr_end)
          begin
            st_q    <= ST_PROG;
            timer_q <= PROG_LEN - 1'b1;
          end
          else
            timer_q <= timer_q - 1'b1;
        ST_PROG:
          if (tmr_end)
            st_q <= ST_IDLE;
          else
            timer_q <= timer_q - 1'b1;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Array update, erase then program
  always_ff @(posedge clk)
  begin
    if (ce && erase_dn && !op_ext_q)
      mem_q[op_addr_q] <= ERASED_BYTE;
    else if (ce && prog_dn && !op_ext_q)
      mem_q[op_addr_q] <= op_data_q;
  end

  // Data register, read result wins over bus write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      data_q <= RESET_BYTE;
    else if (ce)
    begin
      if (st_q == ST_READ)
        data_q <= op_cfg_q ? ext_rdata : mem_q[op_addr_q];
      else if (hit_dat)
        data_q <= wbyte;
    end
  end

  // Far-side request for program memory and configuration
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ext_q <= '0;
    else if (ce)
    begin
      ext_q.wr <= prog_dn & op_ext_q;
      if (prog_dn && op_ext_q)
      begin
        ext_q.cfg  <= op_cfg_q;
        ext_q.addr <= op_addr_q;
        ext_q.data <= op_data_q;
      end
      // Configuration read shows its address to the far side
      else if (rd_go && cfg_q)
      begin
        ext_q.cfg  <= 1'b1;
        ext_q.addr <= cur_addr;
      end
    end
  end

  // ==========================================================
  // Completion flag and interrupt
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      irq_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (prog_dn)
        stat_q <= 1'b1;
      else if (hit_stat && wbyte[IRQ_DONE])
        stat_q <= 1'b0;
      if (hit_mask)
        mask_q <= wbyte[IRQ_DONE];
      irq_q <= stat_q & mask_q;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign ext_req       = ext_q;
  assign irq           = irq_q;

  // ==========================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_RD_NEXT: assert property (ce && rd_go |=> st_q == ST_READ ##1 (st_q == ST_IDLE || !ce))
    else $error("read did not finish in one cycle");
  AST_RD_REFUSED: assert property (ce && hit_ctl && wbyte[CTL_MSEL] && idle |=> st_q != ST_READ)
    else $error("read started with program memory selected");
  AST_WR_GATED: assert property (st_q == ST_IDLE ##1 st_q == ST_ERASE
                                 |-> $past(wallow_q) && $past(unlock_q) == UNLK_ARMED)
    else $error("write started without allow and key");
  AST_WR_BAD_ERR: assert property (ce && wr_bad |=> werr_q && st_q == ST_IDLE)
    else $error("improper write did not flag error");
  AST_WR_NO_CLEAR: assert property (wr_busy && !tmr_end |=> wr_busy)
    else $error("write start dropped before timer end");
  AST_ERASE_LEN: assert property ($rose(st_q == ST_ERASE) |-> timer_q == ERASE_LEN - 1'b1)
    else $error("erase timer loaded wrong");
  AST_ERASE_VAL: assert property (ce && erase_dn && !op_ext_q |=> mem_q[op_addr_q] == ERASED_BYTE)
    else $error("location not erased before program");
  AST_DONE_FLAG: assert property (ce && prog_dn |=> stat_q && st_q == ST_IDLE)
    else $error("done flag not set at write end");
  AST_FLAG_STICKY: assert property (stat_q && !(ce && hit_stat && wbyte[IRQ_DONE]) |=> stat_q)
    else $error("done flag cleared by hardware");
  AST_UNLOCK_ZERO: assert property (ce && s_axi_arvalid && arready_q && s_axi_araddr == OFS_UNLOCK
                                    |=> rdata_q == 32'h00000000)
    else $error("unlock register read not zero");
  AST_EXT_PULSE: assert property (ce && prog_dn && op_ext_q |=> ext_q.wr ##1 (!ext_q.wr || !ce))
    else $error("far-side write pulse wrong");

endmodule : data_eeprom_access
`default_nettype wire

//--- test/nv_array_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far-side store for forwarded program and configuration writes
module nv_array_partner
  import nv_access_pkg::*;
(
  input  wire logic     clk,
  input  wire ext_req_t ext_req,
  output logic [7:0]    ext_rdata,
  output int            n_wr,
  output ext_req_t      last_req
);
  logic [7:0] cfg_mem [MEM_BYTES];

  // Start pattern from the low address byte, repeating every 256 locations
  initial
  begin
    n_wr = 0;
    last_req = '0;
    foreach (cfg_mem[i]) cfg_mem[i] = 8'(i) ^ 8'h3c;
  end

  // Count and keep each forwarded write
  always @(posedge clk)
  begin
    if (ext_req.wr === 1'b1)
    begin
      n_wr <= n_wr + 1;
      last_req <= ext_req;
      if (ext_req.cfg) cfg_mem[ext_req.addr] <= ext_req.data;
    end
  end

  // Configuration byte at the held address
  assign ext_rdata = cfg_mem[ext_req.addr];
endmodule : nv_array_partner
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import nv_access_pkg::*;
  localparam int WCYC  = 20;
  localparam int LIMIT = 20000;
  logic        clk, rst_n, ce, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ext_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, mask_on;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  ext_req_t    ext_req, last_req;
  int          n_wr, mismatches, n_compared, seed_ret;
  int          cycles = 0;
  int          mem [MEM_BYTES];

  data_eeprom_access #(.WRITE_CYCLES_P(WCYC)) u_dut (.clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_rdata, .ext_req, .irq);
  nv_array_partner u_far (.clk, .ext_req, .ext_rdata, .n_wr, .last_req);

  // Clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches++;
      complete_run();
    end
  end

  // ==========================================================
  // Compare tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp

  // ==========================================================
  // Bus cycles
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_resp(r, RESP_OKAY);
  endtask : wr_ok

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_resp(r, RESP_OKAY);
    chk_val(d, e);
  endtask : rd_chk

  // ==========================================================
  // Array operations
  task automatic set_addr(input logic [9:0] a, input logic [7:0] d);
    wr_ok(OFS_ADDR_HIGH, {6'h3f, a[9:8]});
    wr_ok(OFS_ADDR_LOW, a[7:0]);
    wr_ok(OFS_DATA, d);
  endtask : set_addr

  task automatic launch(input logic [7:0] ctl);
    wr_ok(OFS_CONTROL, ctl & 8'hfd);
    wr_ok(OFS_UNLOCK, KEY_FIRST);
    wr_ok(OFS_UNLOCK, KEY_SECOND);
    wr_ok(OFS_CONTROL, ctl);
  endtask : launch

  task automatic finish_wr(input logic [7:0] fin);
    logic [31:0] c;
    logic [1:0]  r;
    do axi_rd(OFS_CONTROL, c, r); while (c[CTL_WR] === 1'b1);
    chk_val(c, 32'(fin));
    rd_chk(OFS_IRQ_STAT, 32'h40);
    chk_val(32'(irq), 32'(mask_on));
    wr_ok(OFS_IRQ_STAT, 8'h40);
    rd_chk(OFS_IRQ_STAT, 32'h0);
    chk_val(32'(irq), 32'h0);
  endtask : finish_wr

  task automatic ee_write(input logic [9:0] a, input logic [7:0] d);
    set_addr(a, d);
    launch(8'h06);
    finish_wr(8'h04);
    mem[a] = int'(d);
  endtask : ee_write

  task automatic ee_read(input logic [9:0] a);
    set_addr(a, 8'h00);
    wr_ok(OFS_CONTROL, 8'h05);
    rd_chk(OFS_DATA, 32'(mem[a]));
    rd_chk(OFS_CONTROL, 32'h04);
  endtask : ee_read

  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [9:0]  a;
    logic [7:0]  d;
    logic [31:0] v;
    logic [1:0]  r;
    seed_ret = $urandom(32'h6bfdb8a9);
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, mask_on} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    ce = 1'b1;
    foreach (mem[i]) mem[i] = -1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int o = 0; o <= 24; o += 4) rd_chk(8'(o), 32'(RESET_BYTE));
    axi_wr(8'h1c, 8'h01, r);
    chk_resp(r, RESP_SLVERR);
    axi_rd(8'h1c, v, r);
    chk_resp(r, RESP_SLVERR);
    chk_val(v, 32'h0);
    wr_ok(OFS_UNLOCK, KEY_FIRST);
    rd_chk(OFS_UNLOCK, 32'h0);
    wr_ok(OFS_ADDR_HIGH, 8'hff);
    rd_chk(OFS_ADDR_HIGH, 32'h3);
    $display("test map done");
    ee_write(10'h3ff, 8'($urandom));
    mask_on = 1'b1;
    wr_ok(OFS_IRQ_MASK, 8'h40);
    ee_write(10'h000, 8'($urandom));
    a = 10'($urandom);
    ee_write(a, 8'h0f);
    ee_write(a, 8'hf0);
    ee_read(10'h3ff);
    ee_read(10'h000);
    ee_read(a);
    $display("test write read done");
    a = 10'($urandom);
    d = 8'($urandom);
    set_addr(a, d);
    launch(8'h06);
    wr_ok(OFS_CONTROL, 8'h04);
    rd_chk(OFS_CONTROL, 32'h06);
    @(posedge clk);
    ce <= 1'b0;
    repeat (30) @(posedge clk);
    ce <= 1'b1;
    rd_chk(OFS_CONTROL, 32'h06);
    finish_wr(8'h04);
    mem[a] = int'(d);
    ee_read(a);
    $display("test busy done");
    wr_ok(OFS_CONTROL, 8'h04);
    wr_ok(OFS_CONTROL, 8'h06);
    rd_chk(OFS_CONTROL, 32'h0c);
    wr_ok(OFS_CONTROL, 8'h00);
    wr_ok(OFS_UNLOCK, KEY_FIRST);
    wr_ok(OFS_UNLOCK, KEY_SECOND);
    wr_ok(OFS_CONTROL, 8'h02);
    rd_chk(OFS_CONTROL, 32'h08);
    rd_chk(OFS_IRQ_STAT, 32'h0);
    ee_read(a);
    wr_ok(OFS_DATA, 8'h5c);
    wr_ok(OFS_CONTROL, 8'h85);
    rd_chk(OFS_DATA, 32'h5c);
    rd_chk(OFS_CONTROL, 32'h84);
    $display("test refusals done");
    d = 8'($urandom);
    set_addr(a, d);
    launch(8'h86);
    finish_wr(8'h84);
    chk_val(32'(n_wr), 32'h1);
    chk_val(32'(last_req), 32'({2'b10, a, d}));
    ee_read(a);
    d = 8'($urandom);
    set_addr(a, d);
    launch(8'h46);
    finish_wr(8'h44);
    chk_val(32'(last_req), 32'({2'b11, a, d}));
    chk_val(32'(n_wr), 32'h2);
    wr_ok(OFS_CONTROL, 8'h45);
    rd_chk(OFS_DATA, 32'(d));
    a = a + 10'h001;
    set_addr(a, 8'h00);
    wr_ok(OFS_CONTROL, 8'h45);
    rd_chk(OFS_DATA, 32'(a[7:0] ^ 8'h3c));
    $display("test targets done");
    set_addr(a, 8'h33);
    launch(8'h06);
    repeat (4) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(OFS_CONTROL, 32'h08);
    $display("test abort done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
